/* File: pkg/cqd_pkg.sv */
// Constants of the flash query database: word offsets, stored bytes and widths.
// Assumes offsets are word addresses relative to the start of an erase block.
`default_nettype none

package cqd_pkg;

  // ----------------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  // 32-KWord blocks: offset within a block is 15 bits wide
  localparam int unsigned BLK_OFF_W   = 15;
  localparam int unsigned QRY_OFF_W   = 8;

  // ----------------------------------------------------------------------
  // Word offsets of the database
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_QUERY_ID_STRING      = 8'h10;
  localparam logic [7:0] OFF_PRIMARY_CMDSET       = 8'h13;
  localparam logic [7:0] OFF_PRIMARY_EXT_PTR      = 8'h15;
  localparam logic [7:0] OFF_ALTERNATE_CMDSET     = 8'h17;
  localparam logic [7:0] OFF_SECONDARY_EXT_PTR    = 8'h19;
  localparam logic [7:0] OFF_CORE_SUPPLY_MIN      = 8'h1b;
  localparam logic [7:0] OFF_CORE_SUPPLY_MAX      = 8'h1c;
  localparam logic [7:0] OFF_PROG_SUPPLY_MIN      = 8'h1d;
  localparam logic [7:0] OFF_PROG_SUPPLY_MAX      = 8'h1e;
  localparam logic [7:0] OFF_TYP_WORD_PROGRAM     = 8'h1f;
  localparam logic [7:0] OFF_TYP_BUFFER_WRITE     = 8'h20;
  localparam logic [7:0] OFF_TYP_BLOCK_ERASE      = 8'h21;
  localparam logic [7:0] OFF_TYP_CHIP_ERASE       = 8'h22;
  localparam logic [7:0] OFF_MAX_WORD_PROGRAM     = 8'h23;
  localparam logic [7:0] OFF_MAX_BUFFER_WRITE     = 8'h24;
  localparam logic [7:0] OFF_MAX_BLOCK_ERASE      = 8'h25;
  localparam logic [7:0] OFF_MAX_CHIP_ERASE       = 8'h26;
  localparam logic [7:0] OFF_DEVICE_SIZE_EXP      = 8'h27;
  localparam logic [7:0] OFF_BUS_INTERFACE_CODE   = 8'h28;

  // ----------------------------------------------------------------------
  // Stored values
  // ----------------------------------------------------------------------
  localparam logic [23:0] VAL_QUERY_ID_STRING     = 24'h595251;
  localparam logic [15:0] VAL_PRIMARY_EXT_PTR     = 16'h010a;
  localparam logic [15:0] VAL_ALTERNATE_CMDSET    = 16'h0000;
  localparam logic [15:0] VAL_SECONDARY_EXT_PTR   = 16'h0000;
  localparam logic [7:0]  VAL_CORE_SUPPLY_MIN     = 8'h17;
  localparam logic [7:0]  VAL_CORE_SUPPLY_MAX     = 8'h20;
  localparam logic [7:0]  VAL_PROG_SUPPLY_MIN     = 8'h85;
  localparam logic [7:0]  VAL_PROG_SUPPLY_MAX     = 8'h95;
  localparam logic [7:0]  VAL_TYP_WORD_PROGRAM    = 8'h08;
  localparam logic [7:0]  VAL_TYP_BUFFER_WRITE    = 8'h09;
  localparam logic [7:0]  VAL_TYP_BLOCK_ERASE     = 8'h0a;
  localparam logic [7:0]  VAL_TYP_CHIP_ERASE      = 8'h00;
  localparam logic [7:0]  VAL_MAX_WORD_PROGRAM    = 8'h01;
  localparam logic [7:0]  VAL_MAX_BUFFER_WRITE    = 8'h01;
  localparam logic [7:0]  VAL_MAX_BLOCK_ERASE     = 8'h02;
  localparam logic [7:0]  VAL_MAX_CHIP_ERASE      = 8'h00;
  localparam logic [15:0] VAL_BUS_INTERFACE_CODE  = 16'h0001;
  localparam logic [7:0]  VAL_UNMAPPED            = 8'h00;
  localparam logic [7:0]  VAL_UPPER_BYTE          = 8'h00;
  localparam logic [15:0] RST_DATA                = 16'h0000;

  // Defaults of top-level parameters
  // Arbitrary neutral code, not any vendor's assignment
  localparam logic [15:0] DEF_PRIMARY_CMDSET      = 16'h00a5;
  localparam logic [7:0]  DEF_DEVICE_SIZE_EXP     = 8'h17;

  // ----------------------------------------------------------------------
  // Read-cycle states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CQD_IDLE  = 2'b01,
    CQD_DRIVE = 2'b10
  } cqd_state_e;

endpackage

`default_nettype wire

/* File: logic/cqd_query_database.sv */
// Read-only query database of a 16-bit parallel flash, behind its read pins.
// Assumes the command decoder raises queryMode; pins are synchronous to clk.
//
// Function
// [RL1] Offsets 10h-12h return ASCII Q, R, Y as the identification string.
// [RL2] Offsets 13h-14h return the two-byte primary command-set code.
// [RL3] Offsets 15h-16h return 0Ah and 01h, pointer to extended table.
// [RL4] Offsets 17h-18h return zero: no alternate command set exists.
// [RL5] Offsets 19h-1Ah return zero: no secondary extended table exists.
// [RL6] Offsets 1Bh-1Ch return core supply voltages 17h and 20h.
// [RL7] Offsets 1Dh-1Eh return programming supply voltages 85h and 95h.
// [RL8] Offsets 1Fh and 20h return typical program exponents 08h and 09h.
// [RL9] Offset 21h returns 0Ah block erase; 22h returns 00h, no chip erase.
// [RL10] Offsets 23h-26h return maximum factors 01h, 01h, 02h, 00h.
// [RL11] Offset 27h returns device size exponent, set by density.
// [RL12] Offsets are taken relative to each block's base address.
// [RL13] Only the low data byte carries data; upper byte is always 00h.
// [RL14] Multi-byte fields put least significant byte at lowest offset.
// [RL15] Contents constant and read-only; answered only while in query mode.
`timescale 1ns/10ps
`default_nettype none

module cqd_query_database #(
  parameter logic [15:0] PRIMARY_CMDSET  = cqd_pkg::DEF_PRIMARY_CMDSET,
  parameter logic [7:0]  DEVICE_SIZE_EXP = cqd_pkg::DEF_DEVICE_SIZE_EXP
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        queryMode,
  input  wire logic                        chipEnable_n,
  input  wire logic                        outputEnable_n,
  input  wire logic [cqd_pkg::ADDR_W-1:0]  address,
  output var  logic [cqd_pkg::DATA_W-1:0]  dataOut,
  output var  logic                        dataOe_n
);
  import cqd_pkg::*;

  // ----------------------------------------------------------------------
  // Byte lookup
  // ----------------------------------------------------------------------
  // Function so the constant table stays in one place
  function automatic logic [BYTE_W-1:0] queryByte(
    input logic [BLK_OFF_W-1:0] blockOffset
  );
    logic [BYTE_W-1:0] b;
    b = VAL_UNMAPPED;
    // Upper offset bits must be zero; anything else is outside the table
    if (blockOffset[BLK_OFF_W-1:QRY_OFF_W] == '0) begin
      unique case (blockOffset[QRY_OFF_W-1:0])
        OFF_QUERY_ID_STRING:          b = VAL_QUERY_ID_STRING[7:0];    // RL1
        OFF_QUERY_ID_STRING + 8'h01:  b = VAL_QUERY_ID_STRING[15:8];   // RL1
        OFF_QUERY_ID_STRING + 8'h02:  b = VAL_QUERY_ID_STRING[23:16];  // RL1
        OFF_PRIMARY_CMDSET:           b = PRIMARY_CMDSET[7:0];         // RL2
        OFF_PRIMARY_CMDSET + 8'h01:   b = PRIMARY_CMDSET[15:8];        // RL14
        OFF_PRIMARY_EXT_PTR:          b = VAL_PRIMARY_EXT_PTR[7:0];    // RL3
        OFF_PRIMARY_EXT_PTR + 8'h01:  b = VAL_PRIMARY_EXT_PTR[15:8];   // RL3
        OFF_ALTERNATE_CMDSET:         b = VAL_ALTERNATE_CMDSET[7:0];   // RL4
        OFF_ALTERNATE_CMDSET + 8'h01: b = VAL_ALTERNATE_CMDSET[15:8];  // RL4
        OFF_SECONDARY_EXT_PTR:        b = VAL_SECONDARY_EXT_PTR[7:0];  // RL5
        OFF_SECONDARY_EXT_PTR + 8'h01: b = VAL_SECONDARY_EXT_PTR[15:8]; // RL5
        OFF_CORE_SUPPLY_MIN:          b = VAL_CORE_SUPPLY_MIN;         // RL6
        OFF_CORE_SUPPLY_MAX:          b = VAL_CORE_SUPPLY_MAX;         // RL6
        OFF_PROG_SUPPLY_MIN:          b = VAL_PROG_SUPPLY_MIN;         // RL7
        OFF_PROG_SUPPLY_MAX:          b = VAL_PROG_SUPPLY_MAX;         // RL7
        OFF_TYP_WORD_PROGRAM:         b = VAL_TYP_WORD_PROGRAM;        // RL8
        OFF_TYP_BUFFER_WRITE:         b = VAL_TYP_BUFFER_WRITE;        // RL8
        OFF_TYP_BLOCK_ERASE:          b = VAL_TYP_BLOCK_ERASE;         // RL9
        OFF_TYP_CHIP_ERASE:           b = VAL_TYP_CHIP_ERASE;          // RL9
        OFF_MAX_WORD_PROGRAM:         b = VAL_MAX_WORD_PROGRAM;        // RL10
        OFF_MAX_BUFFER_WRITE:         b = VAL_MAX_BUFFER_WRITE;        // RL10
        OFF_MAX_BLOCK_ERASE:          b = VAL_MAX_BLOCK_ERASE;         // RL10
        OFF_MAX_CHIP_ERASE:           b = VAL_MAX_CHIP_ERASE;          // RL10
        OFF_DEVICE_SIZE_EXP:          b = DEVICE_SIZE_EXP;             // RL11
        OFF_BUS_INTERFACE_CODE:       b = VAL_BUS_INTERFACE_CODE[7:0];
        OFF_BUS_INTERFACE_CODE + 8'h01: b = VAL_BUS_INTERFACE_CODE[15:8]; // RL14
        default:                      b = VAL_UNMAPPED;
      endcase
    end
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // Read-cycle control
  // ----------------------------------------------------------------------
  cqd_state_e state;
  cqd_state_e next_state;
  logic       readActive;

  // No writes reach this table; only a qualified read drives the pins
  assign readActive = queryMode && !chipEnable_n && !outputEnable_n;  // RL15

  always_comb begin
    next_state = state;
    unique case (state)
      CQD_IDLE:  if (readActive) next_state = CQD_DRIVE;
      CQD_DRIVE: if (!readActive) next_state = CQD_IDLE;
      default:   next_state = CQD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CQD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Enable follows the next state so it lines up with the registered data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOe_n <= 1'b1;
    end else begin
      dataOe_n <= (next_state != CQD_DRIVE);
    end
  end

  // ----------------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------------
  // Address tracked every cycle while driving, so address changes inside
  // one output-enable window read as new words, as on a real async part
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOut <= RST_DATA;
    end else if (readActive) begin
      // Block base bits above the offset are ignored
      dataOut <= {VAL_UPPER_BYTE,                                   // RL13
                  queryByte(address[BLK_OFF_W-1:0])};               // RL12
    end else begin
      dataOut <= RST_DATA;
    end
  end

endmodule

`default_nettype wire

/* File: tb/cqd_checker.sv */
// Concurrent checks on the pins of the query database.
// Assumes one clock domain; bound onto the query database module at the foot.
`timescale 1ns/10ps
`default_nettype none
module cqd_checker #(
  parameter logic [15:0] PRIMARY_CMDSET  = 16'h0000,
  parameter logic [7:0]  DEVICE_SIZE_EXP = 8'h00
) (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       queryMode,
  input wire logic                       chipEnable_n,
  input wire logic                       outputEnable_n,
  input wire logic [cqd_pkg::ADDR_W-1:0] address,
  input wire logic [cqd_pkg::DATA_W-1:0] dataOut,
  input wire logic                       dataOe_n
);
  import cqd_pkg::*;
  // ------------------------------------------------------------------
  // Read checks
  // ------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        rd;
  logic [14:0] off;
  assign rd  = queryMode && !chipEnable_n && !outputEnable_n;
  assign off = address[14:0];
  drive_on_read_a: assert property (rd |=> !dataOe_n)
    else $error("pins idle on read");
  release_idle_a: assert property (!rd |=> dataOe_n && dataOut == 16'h0000)
    else $error("no release");
  upper_byte_a: assert property (!dataOe_n |-> dataOut[15:8] == 8'h00)
    else $error("upper byte");
  id_string_a: assert property (rd && off == 15'h10 |=> dataOut == 16'h0051)
    else $error("id");
  cmdset_hi_a: assert property (rd && off == 15'h14 |=>
    dataOut[7:0] == PRIMARY_CMDSET[15:8]) else $error("cmdset high");
  ext_pointer_a: assert property (rd && off == 15'h16 |=> dataOut == 16'h0001)
    else $error("ptr");
  core_volt_a: assert property (rd && off == 15'h1c |=> dataOut == 16'h0020)
    else $error("vmax");
  size_exp_a: assert property (rd && off == 15'h27 |=>
    dataOut[7:0] == DEVICE_SIZE_EXP) else $error("size");
  block_rel_a: assert property (rd && $past(rd) && $past(rst_n) && off == $past(off) |=>
    $stable(dataOut)) else $error("block base");
  cover property (rd ##1 rd);
  cover property (queryMode && !chipEnable_n && outputEnable_n);
  cover property (rd && address[23:15] != 9'h000);
endmodule
bind cqd_query_database cqd_checker #(.PRIMARY_CMDSET(PRIMARY_CMDSET),
  .DEVICE_SIZE_EXP(DEVICE_SIZE_EXP)) cqd_checker_inst (.clk(clk), .rst_n(rst_n),
  .queryMode(queryMode), .chipEnable_n(chipEnable_n), .outputEnable_n(outputEnable_n),
  .address(address), .dataOut(dataOut), .dataOe_n(dataOe_n));
`default_nettype wire

/* File: tb/cqd_host_model.sv */
// Host model: drives the flash read pins one cycle at a time.
// Assumes the bench calls drive once per clock cycle.
`timescale 1ns/10ps
`default_nettype none
module cqd_host_model (
  input  wire logic        clk,
  output var  logic        queryMode,
  output var  logic        chipEnable_n,
  output var  logic        outputEnable_n,
  output var  logic [23:0] address
);
  // ------------------------------------------------------------------
  // Pin driver
  // ------------------------------------------------------------------
  initial begin
    queryMode      = 1'b0;
    chipEnable_n   = 1'b1;
    outputEnable_n = 1'b1;
    address        = 24'h000000;
  end
  task automatic drive(input logic [2:0] m, input logic [23:0] a);
    @(posedge clk);
    #1;
    queryMode      = m[2];
    chipEnable_n   = m[1];
    outputEnable_n = m[0];
    // Deselected: inverse, so a held value never passes for data
    address        = m[1] ? ~address : a;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the flash query database.
// Assumes the host model owns the read pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cqd_pkg::*;
  localparam logic [15:0] CMD = 16'h3c96; // Arbitrary code
  localparam logic [7:0]  SZ  = 8'h18;
  logic        clk;
  logic        rst_n;
  logic        queryMode;
  logic        chipEnable_n;
  logic        outputEnable_n;
  logic [23:0] address;
  logic [15:0] dataOut;
  logic        dataOe_n;
  logic [16:0] expQ;
  int          errors;
  int          n_tests;
  cqd_query_database #(.PRIMARY_CMDSET(CMD), .DEVICE_SIZE_EXP(SZ)) cqd_query_database_inst (
    .clk(clk), .rst_n(rst_n), .queryMode(queryMode), .chipEnable_n(chipEnable_n),
    .outputEnable_n(outputEnable_n), .address(address), .dataOut(dataOut), .dataOe_n(dataOe_n));
  cqd_host_model cqd_host_model_inst (.clk(clk), .queryMode(queryMode),
    .chipEnable_n(chipEnable_n), .outputEnable_n(outputEnable_n), .address(address));
  // ------------------------------------------------------------------
  // Expectation and checks
  // ------------------------------------------------------------------
  function automatic logic [16:0] model(input logic [2:0] m, input logic [23:0] a);
    logic [7:0] b;
    case (a[14:0])
      15'h10: b = 8'h51;
      15'h11: b = 8'h52;
      15'h12: b = 8'h59;
      15'h13: b = CMD[7:0];
      15'h14: b = CMD[15:8];
      15'h15, 15'h21: b = 8'h0a;
      15'h16, 15'h23, 15'h24, 15'h28: b = 8'h01;
      15'h1b: b = 8'h17;
      15'h1c: b = 8'h20;
      15'h1d: b = 8'h85;
      15'h1e: b = 8'h95;
      15'h1f: b = 8'h08;
      15'h20: b = 8'h09;
      15'h25: b = 8'h02;
      15'h27: b = SZ;
      default: b = 8'h00;
    endcase
    return (m == 3'b100) ? {1'b0, 8'h00, b} : {1'b1, 16'h0000};
  endfunction
  task automatic chk(input logic [16:0] seen, input logic [16:0] want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic step(input logic [2:0] m, input logic [23:0] a);
    cqd_host_model_inst.drive(m, a);
    chk({dataOe_n, dataOut}, expQ);
    expQ = model(m, a);
  endtask
  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    errors++;
    results();
  end
  initial begin
    rst_n   = 1'b0;
    errors  = 0;
    n_tests = 0;
    expQ    = 17'h10000;
    void'($urandom(19176));
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 48; i++) begin
        step(3'b100, {p ? 9'($urandom) : 9'h000, 15'(i)});
      end
      $display("Offset sweep %0d done", p);
    end
    for (int i = 0; i < 400; i++) begin
      step(($urandom % 3 == 0) ? 3'($urandom) : 3'b100,
           ($urandom % 2) ? 24'($urandom) : 24'($urandom % 48));
    end
    $display("Random reads done");
    step(3'b100, 24'h000013);
    // Collect the pending read before reset cuts in
    step(3'b000, 24'h000010);
    #1 rst_n = 1'b0;
    // Let the asynchronous clear settle before looking
    #1;
    chk({dataOe_n, dataOut}, 17'h10000);
    step(3'b000, 24'h000010);
    #1 rst_n = 1'b1;
    // Same offset in three blocks, then output enable dropped mid-run
    step(3'b100, 24'h000010);
    step(3'b100, 24'h008010);
    step(3'b100, 24'hff8010);
    step(3'b101, 24'h000011);
    step(3'b011, 24'h000000);
    step(3'b011, 24'h000000);
    $display("Reset and block corners done");
    results();
  end
endmodule
`default_nettype wire
